// ==== include/calendar_alarm_pkg.sv ====
// Constants and types for the calendar and alarm core
package calendar_alarm_pkg;

    typedef logic [7:0] byte_t;
    typedef logic [3:0] addr_t;

    // Register addresses
    localparam addr_t ADDR_CONTROL_2 = 4'h1;
    localparam addr_t ADDR_SECONDS = 4'h2;
    localparam addr_t ADDR_MINUTES = 4'h3;
    localparam addr_t ADDR_HOURS = 4'h4;
    localparam addr_t ADDR_DAYS = 4'h5;
    localparam addr_t ADDR_DAY_OF_WEEK = 4'h6;
    localparam addr_t ADDR_MONTH_CENTURY = 4'h7;
    localparam addr_t ADDR_YEAR_COUNT = 4'h8;
    localparam addr_t ADDR_ALARM_MINUTE = 4'h9;
    localparam addr_t ADDR_ALARM_HOUR = 4'ha;
    localparam addr_t ADDR_ALARM_DATE = 4'hb;
    localparam addr_t ADDR_ALARM_DOW = 4'hc;

    // Field positions and masks
    localparam int ALARM_FLAG_BIT = 3;
    localparam int CENTURY_BIT = 7;
    localparam int MATCH_OFF_BIT = 7;
    localparam byte_t SEC_MASK = 8'h7f;
    localparam byte_t MIN_MASK = 8'h7f;
    localparam byte_t HOUR_MASK = 8'h3f;
    localparam byte_t DAY_MASK = 8'h3f;
    localparam byte_t DOW_MASK = 8'h07;
    localparam byte_t MONTH_MASK = 8'h1f;
    localparam byte_t YEAR_MASK = 8'hff;
    localparam byte_t ALARM_MIN_MASK = 8'hff;
    localparam byte_t ALARM_HOUR_MASK = 8'hbf;
    localparam byte_t ALARM_DAY_MASK = 8'hbf;
    localparam byte_t ALARM_DOW_MASK = 8'h87;

    // Counter limits in BCD
    localparam byte_t SEC_MAX = 8'h59;
    localparam byte_t MIN_MAX = 8'h59;
    localparam byte_t HOUR_MAX = 8'h23;
    localparam byte_t DOW_MAX = 8'h06;
    localparam byte_t MONTH_MAX = 8'h12;
    localparam byte_t YEAR_MAX = 8'h99;
    localparam byte_t MONTH_FEB = 8'h02;
    localparam byte_t MONTH_APR = 8'h04;
    localparam byte_t MONTH_JUN = 8'h06;
    localparam byte_t MONTH_SEP = 8'h09;
    localparam byte_t MONTH_NOV = 8'h11;
    localparam byte_t DAYS_31 = 8'h31;
    localparam byte_t DAYS_30 = 8'h30;
    localparam byte_t DAYS_29 = 8'h29;
    localparam byte_t DAYS_28 = 8'h28;

    // Reset values
    localparam byte_t RST_ZERO = 8'h00;
    localparam byte_t RST_ONE = 8'h01;
    localparam byte_t RST_ALARM = 8'h80;
    localparam logic RST_CENTURY = 1'b0;

endpackage

// ==== verilog/calendar_alarm_core.sv ====
// Calendar counters, transfer freeze and alarm comparators
`timescale 1ns/1ps
module calendar_alarm_core (
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    input wire logic tick_1hz_i,
    input wire logic xfer_active_i,
    input wire calendar_alarm_pkg::addr_t reg_addr_i,
    input wire logic reg_wr_i,
    input wire calendar_alarm_pkg::byte_t reg_wdata_i,
    output calendar_alarm_pkg::byte_t reg_rdata_o,
    output logic alarm_flag_o
);
    import calendar_alarm_pkg::*;

    // Synchroniser and edge detect for the oscillator tick
    logic tick_meta_reg;
    logic tick_sync_reg;
    logic tick_prev_reg;
    logic tick_pulse;

    // Time and alarm registers
    byte_t sec_reg;
    byte_t min_reg;
    byte_t hour_reg;
    byte_t day_reg;
    logic [2:0] dow_reg;
    logic century_reg;
    byte_t month_reg;
    byte_t year_reg;
    byte_t alarm_min_reg;
    byte_t alarm_hour_reg;
    byte_t alarm_date_reg;
    byte_t alarm_dow_reg;
    logic alarm_flag_reg;
    logic pending_reg;
    logic match_prev_reg;

    // Next-value wires from the carry chain
    byte_t sec_next;
    byte_t min_next;
    byte_t hour_next;
    byte_t day_next;
    logic [2:0] dow_next;
    logic century_next;
    byte_t month_next;
    byte_t year_next;
    logic do_inc;
    logic match_now;
    logic wr_flag;
    byte_t rdata_next;

    // BCD increment with wrap to a floor value
    function automatic byte_t bcd_inc(input byte_t v, input byte_t maxv, input byte_t minv);
        byte_t r;
        r = v;
        if (v == maxv) begin
            r = minv;
        end else if (v[3:0] == 4'h9) begin
            r = {4'(v[7:4] + 4'h1), 4'h0};
        end else begin
            r = {v[7:4], 4'(v[3:0] + 4'h1)};
        end
        return r;
    endfunction

    // Leap test on a BCD year, 00 counts as leap
    function automatic logic is_leap(input byte_t y);
        logic r;
        r = 1'b0;
        if (y[4] == 1'b0) begin
            r = (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
        end else begin
            r = (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
        end
        return r;
    endfunction

    // Last day of a BCD month
    function automatic byte_t last_day(input byte_t m, input byte_t y);
        byte_t r;
        r = DAYS_31;
        if (m == MONTH_FEB) begin
            r = is_leap(y) ? DAYS_29 : DAYS_28;
        end else if ((m == MONTH_APR) || (m == MONTH_JUN) || (m == MONTH_SEP) || (m == MONTH_NOV)) begin
            r = DAYS_30;
        end
        return r;
    endfunction

    // Tick crosses in from the oscillator domain
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            tick_meta_reg <= 1'b0;
            tick_sync_reg <= 1'b0;
            tick_prev_reg <= 1'b0;
        end else begin
            tick_meta_reg <= tick_1hz_i;
            tick_sync_reg <= tick_meta_reg;
            tick_prev_reg <= tick_sync_reg;
        end
    end

    assign tick_pulse = tick_sync_reg && !tick_prev_reg;

    // Increment only outside a transfer, own tick or the held one
    assign do_inc = !xfer_active_i && (tick_pulse || pending_reg);

    // Hold one tick seen during a transfer
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pending_reg <= 1'b0;
        end else if (xfer_active_i) begin
            if (tick_pulse) begin
                pending_reg <= 1'b1;
            end
        end else begin
            pending_reg <= 1'b0;
        end
    end

    // Carry chain from seconds through years to the century bit
    always_comb begin
        sec_next = bcd_inc(sec_reg, SEC_MAX, RST_ZERO);
        min_next = min_reg;
        hour_next = hour_reg;
        day_next = day_reg;
        dow_next = dow_reg;
        month_next = month_reg;
        year_next = year_reg;
        century_next = century_reg;
        if (sec_reg == SEC_MAX) begin
            min_next = bcd_inc(min_reg, MIN_MAX, RST_ZERO);
            if (min_reg == MIN_MAX) begin
                hour_next = bcd_inc(hour_reg, HOUR_MAX, RST_ZERO);
                if (hour_reg == HOUR_MAX) begin
                    dow_next = (dow_reg == DOW_MAX[2:0]) ? 3'h0 : 3'(dow_reg + 3'h1);
                    day_next = bcd_inc(day_reg, last_day(month_reg, year_reg), RST_ONE);
                    if (day_reg == last_day(month_reg, year_reg)) begin
                        month_next = bcd_inc(month_reg, MONTH_MAX, RST_ONE);
                        if (month_reg == MONTH_MAX) begin
                            year_next = bcd_inc(year_reg, YEAR_MAX, RST_ZERO);
                            if (year_reg == YEAR_MAX) begin
                                century_next = !century_reg;
                            end
                        end
                    end
                end
            end
        end
    end

    // Time counters: host writes, else carry chain
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sec_reg <= RST_ZERO;
            min_reg <= RST_ZERO;
            hour_reg <= RST_ZERO;
            day_reg <= RST_ONE;
            dow_reg <= RST_ZERO[2:0];
            month_reg <= RST_ONE;
            year_reg <= RST_ZERO;
            century_reg <= RST_CENTURY;
        end else if (reg_wr_i) begin
            case (reg_addr_i)
                ADDR_SECONDS: sec_reg <= reg_wdata_i & SEC_MASK;
                ADDR_MINUTES: min_reg <= reg_wdata_i & MIN_MASK;
                ADDR_HOURS: hour_reg <= reg_wdata_i & HOUR_MASK;
                ADDR_DAYS: day_reg <= reg_wdata_i & DAY_MASK;
                ADDR_DAY_OF_WEEK: dow_reg <= reg_wdata_i[2:0];
                ADDR_MONTH_CENTURY: begin
                    month_reg <= reg_wdata_i & MONTH_MASK;
                    century_reg <= reg_wdata_i[CENTURY_BIT];
                end
                ADDR_YEAR_COUNT: year_reg <= reg_wdata_i & YEAR_MASK;
                default: ;
            endcase
        end else if (do_inc) begin
            sec_reg <= sec_next;
            min_reg <= min_next;
            hour_reg <= hour_next;
            day_reg <= day_next;
            dow_reg <= dow_next;
            month_reg <= month_next;
            year_reg <= year_next;
            century_reg <= century_next;
        end
    end

    // Alarm registers, disabled after reset
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            alarm_min_reg <= RST_ALARM;
            alarm_hour_reg <= RST_ALARM;
            alarm_date_reg <= RST_ALARM;
            alarm_dow_reg <= RST_ALARM;
        end else if (reg_wr_i) begin
            case (reg_addr_i)
                ADDR_ALARM_MINUTE: alarm_min_reg <= reg_wdata_i & ALARM_MIN_MASK;
                ADDR_ALARM_HOUR: alarm_hour_reg <= reg_wdata_i & ALARM_HOUR_MASK;
                ADDR_ALARM_DATE: alarm_date_reg <= reg_wdata_i & ALARM_DAY_MASK;
                ADDR_ALARM_DOW: alarm_dow_reg <= reg_wdata_i & ALARM_DOW_MASK;
                default: ;
            endcase
        end
    end

    // Enabled comparisons must all agree; disabled ones pass
    assign match_now = (alarm_min_reg[MATCH_OFF_BIT] || (alarm_min_reg[6:0] == min_reg[6:0]))
        && (alarm_hour_reg[MATCH_OFF_BIT] || (alarm_hour_reg[5:0] == hour_reg[5:0]))
        && (alarm_date_reg[MATCH_OFF_BIT] || (alarm_date_reg[5:0] == day_reg[5:0]))
        && (alarm_dow_reg[MATCH_OFF_BIT] || (alarm_dow_reg[2:0] == dow_reg))
        && !(alarm_min_reg[MATCH_OFF_BIT] && alarm_hour_reg[MATCH_OFF_BIT]
             && alarm_date_reg[MATCH_OFF_BIT] && alarm_dow_reg[MATCH_OFF_BIT]);

    assign wr_flag = reg_wr_i && (reg_addr_i == ADDR_CONTROL_2);

    // Remember last match to catch only its rising edge
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            match_prev_reg <= 1'b0;
        end else begin
            match_prev_reg <= match_now;
        end
    end

    // Alarm flag: set on first match, AND on write, set wins
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            alarm_flag_reg <= 1'b0;
        end else if (match_now && !match_prev_reg) begin
            alarm_flag_reg <= 1'b1;
        end else if (wr_flag) begin
            alarm_flag_reg <= alarm_flag_reg & reg_wdata_i[ALARM_FLAG_BIT];
        end
    end

    // Read multiplexer; unused bits and unmapped addresses read zero
    always_comb begin
        case (reg_addr_i)
            ADDR_CONTROL_2: rdata_next = byte_t'({alarm_flag_reg, 3'h0});
            ADDR_SECONDS: rdata_next = sec_reg;
            ADDR_MINUTES: rdata_next = min_reg;
            ADDR_HOURS: rdata_next = hour_reg;
            ADDR_DAYS: rdata_next = day_reg;
            ADDR_DAY_OF_WEEK: rdata_next = {5'h00, dow_reg};
            ADDR_MONTH_CENTURY: rdata_next = {century_reg, month_reg[6:0]};
            ADDR_YEAR_COUNT: rdata_next = year_reg;
            ADDR_ALARM_MINUTE: rdata_next = alarm_min_reg;
            ADDR_ALARM_HOUR: rdata_next = alarm_hour_reg;
            ADDR_ALARM_DATE: rdata_next = alarm_date_reg;
            ADDR_ALARM_DOW: rdata_next = alarm_dow_reg;
            default: rdata_next = RST_ZERO;
        endcase
    end

    // Registered read data
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            reg_rdata_o <= RST_ZERO;
        end else begin
            reg_rdata_o <= rdata_next;
        end
    end

    assign alarm_flag_o = alarm_flag_reg;

endmodule

// ==== test/calendar_alarm_core_sva.sv ====
// Port-level assertion checker for the calendar and alarm core
`timescale 1ns/1ps
module calendar_alarm_core_chk (
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    input wire logic tick_1hz_i,
    input wire logic xfer_active_i,
    input wire calendar_alarm_pkg::addr_t reg_addr_i,
    input wire logic reg_wr_i,
    input wire calendar_alarm_pkg::byte_t reg_wdata_i,
    input wire calendar_alarm_pkg::byte_t reg_rdata_o,
    input wire logic alarm_flag_o
);
    import calendar_alarm_pkg::*;
    // One clock domain, reset disables all checks
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!reset_n_i);
    // Read-back field layouts
    property p_dow_bits; reg_addr_i == ADDR_DAY_OF_WEEK |=> reg_rdata_o[7:3] == 5'h00; endproperty
    a_dow_bits: assert property (p_dow_bits) else $error("weekday high bits set");
    property p_month_bits; reg_addr_i == ADDR_MONTH_CENTURY |=> reg_rdata_o[6:5] == 2'h0; endproperty
    a_month_bits: assert property (p_month_bits) else $error("month unused bits set");
    property p_hour_alarm_bits; reg_addr_i == ADDR_ALARM_HOUR |=> !reg_rdata_o[6]; endproperty
    a_hour_alarm_bits: assert property (p_hour_alarm_bits) else $error("hour alarm bit 6 set");
    property p_date_alarm_bits; reg_addr_i == ADDR_ALARM_DATE |=> !reg_rdata_o[6]; endproperty
    a_date_alarm_bits: assert property (p_date_alarm_bits) else $error("date alarm bit 6 set");
    property p_dow_alarm_bits; reg_addr_i == ADDR_ALARM_DOW |=> reg_rdata_o[6:3] == 4'h0; endproperty
    a_dow_alarm_bits: assert property (p_dow_alarm_bits) else $error("weekday alarm unused bits set");
    // Counters hold still through a transfer
    property p_freeze; $past(xfer_active_i) && !$past(reg_wr_i) && reg_addr_i == $past(reg_addr_i)
        && reg_addr_i inside {[4'h2:4'h8]} |=> $stable(reg_rdata_o); endproperty
    a_freeze: assert property (p_freeze) else $error("time register moved during transfer");
    // Flag write is an AND with bit 3
    property p_flag_keep; reg_wr_i && reg_addr_i == ADDR_CONTROL_2 && reg_wdata_i[3] && alarm_flag_o
        |=> alarm_flag_o; endproperty
    a_flag_keep: assert property (p_flag_keep) else $error("flag lost on write of one");
    property p_flag_fall; $fell(alarm_flag_o)
        |-> $past(reg_wr_i && reg_addr_i == ADDR_CONTROL_2 && !reg_wdata_i[3]); endproperty
    a_flag_fall: assert property (p_flag_fall) else $error("flag cleared without write");
endmodule
bind calendar_alarm_core calendar_alarm_core_chk i_calendar_alarm_core_chk (.ref_clk_i(ref_clk_i),
    .reset_n_i(reset_n_i), .tick_1hz_i(tick_1hz_i), .xfer_active_i(xfer_active_i), .reg_addr_i(reg_addr_i),
    .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .alarm_flag_o(alarm_flag_o));

// ==== test/host_bus_model.sv ====
// Host side model driving register transfers
`timescale 1ns/1ps
module host_bus_model (
    input wire logic ref_clk_i,
    input wire calendar_alarm_pkg::byte_t rdata_i,
    output logic xfer_o,
    output calendar_alarm_pkg::addr_t addr_o,
    output logic wr_o,
    output calendar_alarm_pkg::byte_t wdata_o
);
    import calendar_alarm_pkg::*;
    // Idle bus at time zero
    initial begin
        xfer_o = 1'b0;
        addr_o = 4'h0;
        wr_o = 1'b0;
        wdata_o = 8'h00;
    end
    // Open or close a transfer; kept far below one second
    task automatic xfer(input logic on);
        @(posedge ref_clk_i);
        xfer_o <= on;
    endtask
    // Single byte write; data inverted once released
    task automatic write_reg(input addr_t a, input byte_t d);
        @(posedge ref_clk_i);
        addr_o <= a;
        wdata_o <= d;
        wr_o <= 1'b1;
        @(posedge ref_clk_i);
        wr_o <= 1'b0;
        wdata_o <= ~d;
    endtask
    // Single byte read, data one cycle after address
    task automatic read_reg(input addr_t a, output byte_t d);
        @(posedge ref_clk_i);
        addr_o <= a;
        @(posedge ref_clk_i);
        #1 d = rdata_i;
    endtask
    // Seconds through years written in one transfer
    task automatic set_time(input byte_t v[7]);
        xfer(1'b1);
        foreach (v[i]) write_reg(ADDR_SECONDS + addr_t'(i), v[i]);
        xfer(1'b0);
    endtask
    // Pointer at seconds, seven reads, then stop
    task automatic get_time(output byte_t v[7]);
        xfer(1'b1);
        foreach (v[i]) read_reg(ADDR_SECONDS + addr_t'(i), v[i]);
        xfer(1'b0);
    endtask
endmodule

// ==== test/tb_calendar_alarm_core.sv ====
// Self-checking bench for the calendar and alarm core
`timescale 1ns/1ps
module tb_calendar_alarm_core;
    import calendar_alarm_pkg::*;
    logic ref_clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic tick_1hz_i = 1'b0;
    logic xfer_active;
    logic reg_wr;
    logic alarm_flag;
    addr_t reg_addr;
    byte_t reg_wdata;
    byte_t reg_rdata;
    byte_t got[7];
    byte_t d;
    int num_errors = 0;
    int n_checks = 0;
    int cycles = 0;
    // Clock and hang guard
    always #5 ref_clk_i = ~ref_clk_i;
    always @(posedge ref_clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            give_verdict();
        end
    end
    calendar_alarm_core i_calendar_alarm_core (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
        .tick_1hz_i(tick_1hz_i), .xfer_active_i(xfer_active), .reg_addr_i(reg_addr), .reg_wr_i(reg_wr),
        .reg_wdata_i(reg_wdata), .reg_rdata_o(reg_rdata), .alarm_flag_o(alarm_flag));
    host_bus_model i_host_bus_model (.ref_clk_i(ref_clk_i), .rdata_i(reg_rdata), .xfer_o(xfer_active),
        .addr_o(reg_addr), .wr_o(reg_wr), .wdata_o(reg_wdata));
    task automatic check(input byte_t seen, input byte_t exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        $display("Checks %0d, errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // One oscillator tick, long enough for the synchroniser
    task automatic tick();
        @(posedge ref_clk_i);
        tick_1hz_i <= 1'b1;
        repeat (4) @(posedge ref_clk_i);
        tick_1hz_i <= 1'b0;
        repeat (4) @(posedge ref_clk_i);
    endtask
    task automatic wr(input addr_t a, input byte_t v);
        i_host_bus_model.write_reg(a, v);
    endtask
    task automatic flag(input logic exp);
        repeat (2) @(posedge ref_clk_i);
        #1;
        check({7'h00, alarm_flag}, {7'h00, exp});
    endtask
    // Packed time, seconds in the top byte
    task automatic set_pack(input logic [55:0] pv);
        byte_t v[7];
        foreach (v[i]) v[i] = pv[55-8*i -: 8];
        i_host_bus_model.set_time(v);
    endtask
    task automatic run_case(input logic [55:0] pv, input logic [55:0] pe);
        set_pack(pv);
        tick();
        i_host_bus_model.get_time(got);
        foreach (got[i]) check(got[i], pe[55-8*i -: 8]);
    endtask
    task automatic test_reset();
        addr_t a[9] = '{4'h6, 4'h7, 4'h8, 4'h9, 4'ha, 4'hb, 4'hc, 4'h1, 4'hf};
        byte_t e[9] = '{8'h00, 8'h01, 8'h00, 8'h80, 8'h80, 8'h80, 8'h80, 8'h00, 8'h00};
        foreach (a[i]) begin
            i_host_bus_model.read_reg(a[i], d);
            check(d, e[i]);
        end
    endtask
    task automatic test_calendar();
        run_case(56'h59592331061299, 56'h00000001008100);
        run_case(56'h59592331029299, 56'h00000001030100);
        run_case(56'h59592328010200, 56'h00000029020200);
        run_case(56'h59592328010201, 56'h00000001020301);
        run_case(56'h59592330050409, 56'h00000001060509);
        run_case(56'h59590915030919, 56'h00001015030919);
    endtask
    // Two ticks during a transfer, only one survives
    task automatic test_freeze();
        set_pack(56'h10001001000101);
        i_host_bus_model.xfer(1'b1);
        i_host_bus_model.read_reg(ADDR_SECONDS, d);
        check(d, 8'h10);
        tick();
        tick();
        i_host_bus_model.read_reg(ADDR_SECONDS, d);
        check(d, 8'h10);
        i_host_bus_model.xfer(1'b0);
        i_host_bus_model.read_reg(ADDR_SECONDS, d);
        check(d, 8'h11);
    endtask
    // Minute and weekday enabled, hour disabled with a mismatching value
    task automatic test_alarm();
        wr(ADDR_ALARM_MINUTE, 8'h01);
        wr(ADDR_ALARM_HOUR, 8'h99);
        wr(ADDR_ALARM_DOW, 8'h04);
        set_pack(56'h59001005030100);
        tick();
        flag(1'b0);
        set_pack(56'h59001005040100);
        tick();
        flag(1'b1);
        wr(ADDR_CONTROL_2, 8'h08);
        flag(1'b1);
        wr(ADDR_CONTROL_2, 8'hf7);
        flag(1'b0);
        tick();
        flag(1'b0);
        set_pack(56'h59001005040100);
        tick();
        flag(1'b1);
    endtask
    // Hour and date enabled, minute and weekday off; unused bits written as ones
    task automatic test_alarm_hour_date();
        wr(ADDR_ALARM_HOUR, 8'h61);
        wr(ADDR_ALARM_DATE, 8'h66);
        wr(ADDR_ALARM_MINUTE, 8'h80);
        wr(ADDR_ALARM_DOW, 8'hff);
        i_host_bus_model.read_reg(ADDR_ALARM_HOUR, d);
        check(d, 8'h21);
        i_host_bus_model.read_reg(ADDR_ALARM_DATE, d);
        check(d, 8'h26);
        i_host_bus_model.read_reg(ADDR_ALARM_DOW, d);
        check(d, 8'h87);
        wr(ADDR_CONTROL_2, 8'h00);
        flag(1'b0);
        set_pack(56'h59592025040100);
        tick();
        flag(1'b0);
        set_pack(56'h59592026040100);
        tick();
        flag(1'b1);
    endtask
    // Reset in mid-run brings back the defaults
    task automatic test_mid_reset();
        wr(ADDR_MONTH_CENTURY, 8'h92);
        i_host_bus_model.read_reg(ADDR_MONTH_CENTURY, d);
        check(d, 8'h92);
        @(posedge ref_clk_i);
        reset_n_i <= 1'b0;
        repeat (2) @(posedge ref_clk_i);
        reset_n_i <= 1'b1;
        test_reset();
    endtask
    // Main sequence
    initial begin
        repeat (5) @(posedge ref_clk_i);
        reset_n_i <= 1'b1;
        test_reset();
        test_calendar();
        test_freeze();
        test_alarm();
        test_alarm_hour_date();
        test_mid_reset();
        give_verdict();
    end
endmodule
